// ### mrs_core_model.sv
// Far-side model: the reset pin source and the core issuing halt and clear-watchdog.
// Assumes bench commands change just after rising edges of ref_clk.
`timescale 1ns/100ps
module mrs_core_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic core_run_ff,
  input wire logic pin_low,
  input wire logic halt_cmd,
  input wire logic wake_cmd,
  input wire logic kick_en,
  output logic ext_reset_pin_n,
  output logic halt_exec,
  output logic clr_wdt_exec,
  output logic wake_req
);
  logic [5:0] kick_cnt_ff;
  // The core only issues instructions while it is allowed to run.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      kick_cnt_ff <= 6'h00;
      ext_reset_pin_n <= 1'b1;
      halt_exec <= 1'b0;
      clr_wdt_exec <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      kick_cnt_ff <= kick_cnt_ff + 6'h01;
      ext_reset_pin_n <= !pin_low;
      halt_exec <= halt_cmd && core_run_ff;
      clr_wdt_exec <= kick_en && core_run_ff && kick_cnt_ff == 6'h3f;
      wake_req <= wake_cmd;
    end
  end
endmodule : mrs_core_model

// ### mrs_pkg.sv
// Constants, field positions, reset values and state type of the reset sequencer.
// Assumes a single 50 MHz system clock and an APB register port with 8-bit addresses.
package mrs_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int SST_PULSES = 1024;
  localparam logic [10:0] SST_LAST = 11'(SST_PULSES - 1);
  localparam int WDT_BASE_DEFAULT = 1024;
  localparam int WDT_CW = 18;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_WDT_SCALE = 8'h08;
  localparam logic [7:0] OFS_IRQ_CTRL = 8'h0c;
  localparam logic [7:0] OFS_PORT_A_DATA = 8'h10;
  localparam logic [7:0] OFS_PORT_A_DIR = 8'h14;
  localparam logic [7:0] OFS_PORT_B_DATA = 8'h18;
  localparam logic [7:0] OFS_PORT_B_DIR = 8'h1c;
  localparam logic [7:0] OFS_PWM_CTRL = 8'h20;
  localparam logic [7:0] OFS_EV_STATUS = 8'h24;
  localparam logic [7:0] OFS_EV_MASK = 8'h28;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [7:0] WDT_SCALE_RST = 8'h07;
  localparam logic [6:0] IRQ_CTRL_RST = 7'h00;
  localparam logic [7:0] PORT_A_RST = 8'hff;
  localparam logic [3:0] PORT_B_RST = 4'hf;
  localparam logic [7:0] PWM_CTRL_RST = 8'h00;
  localparam logic [7:0] PWM_CTRL_DEF = 8'h8d;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CTRL_WDT_EN = 0;
  localparam int ST_TO = 0;
  localparam int ST_PDF = 1;
  localparam int ST_HALTED = 2;
  localparam int ST_BUSY = 3;
  localparam int EV_PIN = 0;
  localparam int EV_WDT = 1;
  localparam int EV_WARM = 2;
  localparam int EV_WAKE = 3;
  localparam int EV_NUM = 4;

  typedef enum logic [1:0] {MRS_SST, MRS_RUN, MRS_HALT, MRS_PIN_HOLD} mrs_state_t;

endpackage : mrs_pkg

// ### mrs_reset_sequencer.sv
// Reset and start-up sequencer with watchdog, reset-cause flags and register reset states.
// Assumes a 50 MHz ref_clk, power-on reset on reset, an APB master and an asynchronous reset pin.
`timescale 1ns/100ps
module mrs_reset_sequencer
  import mrs_pkg::*;
#(
  parameter int WDT_BASE = WDT_BASE_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  output logic irq_ff,
  input wire logic ext_reset_pin_n,
  input wire logic halt_exec,
  input wire logic clr_wdt_exec,
  input wire logic wake_req,
  output logic core_run_ff,
  output logic pc_sp_clear_ff,
  output logic unit_reset_ff,
  output logic timeout_flag_ff,
  output logic powerdown_flag_ff,
  output logic [7:0] watchdog_scale_ff,
  output logic [6:0] irq_control_ff,
  output logic [7:0] port_a_data_ff,
  output logic [7:0] port_a_dir_ff,
  output logic [3:0] port_b_data_ff,
  output logic [3:0] port_b_dir_ff,
  output logic [7:0] audio_pwm_ctrl_ff
);

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  function automatic logic reg_mapped(input logic [7:0] a);
    case (a)
      OFS_CTRL, OFS_STATUS, OFS_WDT_SCALE, OFS_IRQ_CTRL, OFS_PORT_A_DATA, OFS_PORT_A_DIR,
      OFS_PORT_B_DATA, OFS_PORT_B_DIR, OFS_PWM_CTRL, OFS_EV_STATUS, OFS_EV_MASK: reg_mapped = 1'b1;
      default: reg_mapped = 1'b0;
    endcase
  endfunction : reg_mapped

  mrs_state_t state_ff;
  mrs_state_t nxt_state;
  logic [10:0] sst_cnt_ff;
  logic sst_after_ff;
  logic pin_s1_ff;
  logic pin_s2_ff;
  logic pin_s3_ff;
  logic pin_low_ff;
  logic [7:0] ctrl_ff;
  logic [EV_NUM-1:0] ev_status_ff;
  logic [EV_NUM-1:0] ev_mask_ff;
  logic wdt_clear_ff;
  logic ev_pin;
  logic ev_wdt_run;
  logic ev_wdt_halt;
  logic ev_wake;
  logic ev_halt;
  logic ev_clrwdt;
  logic chip_reset;
  logic ev_sst_done;
  logic apb_access;
  logic wr_go;
  logic rd_go;
  logic [EV_NUM-1:0] ev_set;
  logic [31:0] rd_mux;

  mrs_wdt_if wdt_bus ();

  assign wdt_bus.clear = wdt_clear_ff;
  assign wdt_bus.enable = ctrl_ff[CTRL_WDT_EN];
  assign wdt_bus.scale = watchdog_scale_ff[2:0];

  mrs_watchdog_timer #(
    .WDT_BASE(WDT_BASE)
  ) u_watchdog_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .w(wdt_bus.wdt)
  );

  // ---------------------------------------------------------------------------
  // Reset pin synchroniser
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pin_s1_ff <= 1'b1;
      pin_s2_ff <= 1'b1;
      pin_s3_ff <= 1'b1;
      pin_low_ff <= 1'b0;
    end else begin
      pin_s1_ff <= ext_reset_pin_n;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      if (pin_s2_ff == pin_s3_ff) begin
        pin_low_ff <= ~pin_s3_ff;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Event decode
  // ---------------------------------------------------------------------------
  // Pin outranks watchdog, which outranks halt, wake and clear-watchdog.
  assign ev_pin = pin_low_ff && (state_ff != MRS_PIN_HOLD);
  assign ev_wdt_run = wdt_bus.overflow && !pin_low_ff && (state_ff == MRS_RUN);
  assign ev_wdt_halt = wdt_bus.overflow && !pin_low_ff && (state_ff == MRS_HALT);
  assign ev_wake = wake_req && !wdt_bus.overflow && !pin_low_ff && (state_ff == MRS_HALT);
  assign ev_halt = halt_exec && !wdt_bus.overflow && !pin_low_ff && (state_ff == MRS_RUN);
  assign ev_clrwdt = clr_wdt_exec && !halt_exec && !wdt_bus.overflow && !pin_low_ff && (state_ff == MRS_RUN);
  assign chip_reset = ev_pin || ev_wdt_run;
  assign ev_sst_done = (state_ff == MRS_SST) && (sst_cnt_ff == SST_LAST) && !pin_low_ff;

  // ---------------------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      MRS_SST: begin
        if (ev_pin) begin
          nxt_state = MRS_PIN_HOLD;
        end else if (ev_sst_done) begin
          nxt_state = MRS_RUN;
        end
      end
      MRS_RUN: begin
        if (ev_pin) begin
          nxt_state = MRS_PIN_HOLD;
        end else if (ev_wdt_run) begin
          nxt_state = MRS_RUN;
        end else if (ev_halt) begin
          nxt_state = MRS_HALT;
        end
      end
      MRS_HALT: begin
        if (ev_pin) begin
          nxt_state = MRS_PIN_HOLD;
        end else if (ev_wdt_halt || ev_wake) begin
          nxt_state = MRS_SST;
        end
      end
      MRS_PIN_HOLD: begin
        if (!pin_low_ff) begin
          nxt_state = sst_after_ff ? MRS_SST : MRS_RUN;
        end
      end
      default: begin
        nxt_state = MRS_SST;
      end
    endcase
  end

  // Power-up starts in the start-up delay, inside the reset period.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_ff <= MRS_SST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sst_cnt_ff <= '0;
    end else if (state_ff == MRS_SST && nxt_state == MRS_SST) begin
      sst_cnt_ff <= sst_cnt_ff + 11'h001;
    end else begin
      sst_cnt_ff <= '0;
    end
  end

  // A pin reset taken while halted or still starting up wakes through the delay.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sst_after_ff <= 1'b0;
    end else if (ev_pin) begin
      sst_after_ff <= (state_ff != MRS_RUN);
    end
  end

  // ---------------------------------------------------------------------------
  // Core and unit controls
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      core_run_ff <= 1'b0;
      pc_sp_clear_ff <= 1'b1;
      unit_reset_ff <= 1'b1;
    end else begin
      core_run_ff <= (nxt_state == MRS_RUN) && !chip_reset;
      pc_sp_clear_ff <= chip_reset || ev_wdt_halt || (state_ff == MRS_PIN_HOLD);
      unit_reset_ff <= chip_reset || (state_ff == MRS_PIN_HOLD);
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wdt_clear_ff <= 1'b1;
    end else begin
      // Counting resumes the cycle after a chip reset ends, or after the start-up delay when MRS_SST follows.
      wdt_clear_ff <= chip_reset || ev_halt || ev_clrwdt || ev_wdt_halt || (nxt_state == MRS_PIN_HOLD)
        || (nxt_state == MRS_SST);
    end
  end

  // ---------------------------------------------------------------------------
  // Reset cause flags
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      timeout_flag_ff <= 1'b0;
      powerdown_flag_ff <= 1'b0;
    end else if (ev_pin && state_ff == MRS_HALT) begin
      timeout_flag_ff <= 1'b0;
      powerdown_flag_ff <= 1'b1;
    end else if (ev_wdt_run) begin
      timeout_flag_ff <= 1'b1;
    end else if (ev_wdt_halt) begin
      timeout_flag_ff <= 1'b1;
      powerdown_flag_ff <= 1'b1;
    end else if (ev_halt) begin
      timeout_flag_ff <= 1'b0;
      powerdown_flag_ff <= 1'b1;
    end else if (ev_clrwdt) begin
      powerdown_flag_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------------------
  assign apb_access = psel && penable && !pready_ff;
  assign wr_go = psel && penable && pready_ff && pwrite;
  assign rd_go = psel && penable && pready_ff && !pwrite;

  always_comb begin
    rd_mux = '0;
    case (paddr)
      OFS_CTRL: rd_mux[7:0] = ctrl_ff;
      OFS_STATUS: begin
        rd_mux[ST_TO] = timeout_flag_ff;
        rd_mux[ST_PDF] = powerdown_flag_ff;
        rd_mux[ST_HALTED] = (state_ff == MRS_HALT);
        rd_mux[ST_BUSY] = (state_ff == MRS_SST) || (state_ff == MRS_PIN_HOLD);
      end
      OFS_WDT_SCALE: rd_mux[7:0] = watchdog_scale_ff;
      OFS_IRQ_CTRL: rd_mux[6:0] = irq_control_ff;
      OFS_PORT_A_DATA: rd_mux[7:0] = port_a_data_ff;
      OFS_PORT_A_DIR: rd_mux[7:0] = port_a_dir_ff;
      OFS_PORT_B_DATA: rd_mux[3:0] = port_b_data_ff;
      OFS_PORT_B_DIR: rd_mux[3:0] = port_b_dir_ff;
      OFS_PWM_CTRL: rd_mux[7:0] = audio_pwm_ctrl_ff;
      OFS_EV_STATUS: rd_mux[EV_NUM-1:0] = ev_status_ff;
      OFS_EV_MASK: rd_mux[EV_NUM-1:0] = ev_mask_ff;
      default: rd_mux = '0;
    endcase
  end

  // One wait state: data and error are registered in the first access cycle.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= apb_access;
      pslverr_ff <= apb_access && !reg_mapped(paddr);
      if (apb_access && !pwrite) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      watchdog_scale_ff <= WDT_SCALE_RST;
      irq_control_ff <= IRQ_CTRL_RST;
      port_a_data_ff <= PORT_A_RST;
      port_a_dir_ff <= PORT_A_RST;
      port_b_data_ff <= PORT_B_RST;
      port_b_dir_ff <= PORT_B_RST;
    end else if (chip_reset || state_ff == MRS_PIN_HOLD) begin
      // Interrupts off and ports back to input mode; a warm reset skips this.
      watchdog_scale_ff <= WDT_SCALE_RST;
      irq_control_ff <= IRQ_CTRL_RST;
      port_a_data_ff <= PORT_A_RST;
      port_a_dir_ff <= PORT_A_RST;
      port_b_data_ff <= PORT_B_RST;
      port_b_dir_ff <= PORT_B_RST;
    end else if (wr_go) begin
      case (paddr)
        OFS_WDT_SCALE: watchdog_scale_ff <= pwdata[7:0];
        OFS_IRQ_CTRL: irq_control_ff <= pwdata[6:0];
        OFS_PORT_A_DATA: port_a_data_ff <= pwdata[7:0];
        OFS_PORT_A_DIR: port_a_dir_ff <= pwdata[7:0];
        OFS_PORT_B_DATA: port_b_data_ff <= pwdata[3:0];
        OFS_PORT_B_DIR: port_b_dir_ff <= pwdata[3:0];
        default: begin
        end
      endcase
    end
  end

  // Only power-on touches the PWM control; every other reset keeps it.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      audio_pwm_ctrl_ff <= PWM_CTRL_RST;
    end else if (wr_go && paddr == OFS_PWM_CTRL) begin
      audio_pwm_ctrl_ff <= pwdata[7:0] & PWM_CTRL_DEF;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_ff <= CTRL_RST;
      ev_mask_ff <= '0;
    end else if (wr_go) begin
      if (paddr == OFS_CTRL) begin
        ctrl_ff <= pwdata[7:0];
      end
      if (paddr == OFS_EV_MASK) begin
        ev_mask_ff <= pwdata[EV_NUM-1:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Event status and interrupt
  // ---------------------------------------------------------------------------
  assign ev_set[EV_PIN] = ev_pin;
  assign ev_set[EV_WDT] = ev_wdt_run;
  assign ev_set[EV_WARM] = ev_wdt_halt;
  assign ev_set[EV_WAKE] = ev_sst_done;

  // A read clears only the bits it returned, and a new event wins over the clear.
  for (genvar i = 0; i < EV_NUM; i++) begin : g_ev
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        ev_status_ff[i] <= 1'b0;
      end else if (ev_set[i]) begin
        ev_status_ff[i] <= 1'b1;
      end else if (rd_go && paddr == OFS_EV_STATUS && prdata_ff[i]) begin
        ev_status_ff[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(ev_status_ff & ev_mask_ff);
    end
  end

endmodule : mrs_reset_sequencer

// ### mrs_reset_sequencer_sva.sv
// Port checker of the reset sequencer.
// Assumes it is bound into mrs_reset_sequencer and sees only its ports.
`timescale 1ns/100ps
module mrs_seq_chk
  import mrs_pkg::*;
#(
  parameter int WDT_BASE = WDT_BASE_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready_ff,
  input wire logic ext_reset_pin_n,
  input wire logic halt_exec,
  input wire logic clr_wdt_exec,
  input wire logic core_run_ff,
  input wire logic pc_sp_clear_ff,
  input wire logic unit_reset_ff,
  input wire logic timeout_flag_ff,
  input wire logic powerdown_flag_ff,
  input wire logic [7:0] watchdog_scale_ff,
  input wire logic [6:0] irq_control_ff,
  input wire logic [7:0] port_a_data_ff,
  input wire logic [7:0] port_a_dir_ff,
  input wire logic [3:0] port_b_data_ff,
  input wire logic [3:0] port_b_dir_ff,
  input wire logic [7:0] audio_pwm_ctrl_ff
);
  // Counts edges since reset release, saturating, to time the start-up delay.
  logic [10:0] since_ff;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      since_ff <= 11'h000;
    end else if (since_ff != 11'h7ff) begin
      since_ff <= since_ff + 11'h001;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_pin_low;
    !ext_reset_pin_n [*8];
  endsequence
  sequence s_chip_vals;
    watchdog_scale_ff == 8'h07 && irq_control_ff == 7'h00 && port_a_data_ff == 8'hff
      && port_a_dir_ff == 8'hff && port_b_data_ff == 4'hf && port_b_dir_ff == 4'hf;
  endsequence
  property p_por_vals; $past(reset) |-> s_chip_vals; endproperty
  a_por_vals: assert property (p_por_vals) else $error("power-on register values wrong");
  property p_por_pwm;
    $past(reset) |-> audio_pwm_ctrl_ff == 8'h00 && !timeout_flag_ff && !powerdown_flag_ff;
  endproperty
  a_por_pwm: assert property (p_por_pwm) else $error("power-on pwm or flags wrong");
  property p_sst_hold; since_ff < 11'h400 |-> !core_run_ff; endproperty
  a_sst_hold: assert property (p_sst_hold) else $error("core ran inside start-up delay");
  property p_sst_done; since_ff == 11'h400 |-> core_run_ff; endproperty
  a_sst_done: assert property (p_sst_done) else $error("core not running after delay");
  property p_halt; halt_exec && core_run_ff && ext_reset_pin_n |-> ##[1:2] powerdown_flag_ff && !timeout_flag_ff;
  endproperty
  a_halt: assert property (p_halt) else $error("halt flags wrong");
  property p_clr;
    clr_wdt_exec && !halt_exec && core_run_ff && ext_reset_pin_n |-> ##[1:2] !powerdown_flag_ff;
  endproperty
  a_clr: assert property (p_clr) else $error("clear-watchdog left powerdown set");
  property p_to_pc; $rose(timeout_flag_ff) |-> ##[0:2] pc_sp_clear_ff; endproperty
  a_to_pc: assert property (p_to_pc) else $error("time-out without pc clear");
  property p_warm;
    pc_sp_clear_ff && !unit_reset_ff |-> $stable(watchdog_scale_ff) && $stable(port_a_data_ff)
      && $stable(audio_pwm_ctrl_ff);
  endproperty
  a_warm: assert property (p_warm) else $error("warm reset changed registers");
  property p_chip_load; unit_reset_ff |-> ##[0:1] s_chip_vals; endproperty
  a_chip_load: assert property (p_chip_load) else $error("chip reset values wrong");
  property p_chip_pwm; unit_reset_ff |-> $stable(audio_pwm_ctrl_ff); endproperty
  a_chip_pwm: assert property (p_chip_pwm) else $error("chip reset touched pwm control");
  property p_pin_sync; $fell(ext_reset_pin_n) && core_run_ff |=> core_run_ff; endproperty
  a_pin_sync: assert property (p_pin_sync) else $error("pin acted unsynchronised");
  property p_pin_hold; s_pin_low |-> unit_reset_ff && pc_sp_clear_ff && !core_run_ff; endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin hold not resetting");
  property p_apb; psel && penable && !pready_ff |=> pready_ff; endproperty
  a_apb: assert property (p_apb) else $error("apb answer late");
endmodule : mrs_seq_chk

bind mrs_reset_sequencer mrs_seq_chk #(.WDT_BASE(WDT_BASE)) u_chk (.*);

// ### mrs_reset_sequencer_tb.sv
// Self-checking bench of the reset sequencer with random register data.
// Assumes mrs_core_model stands for pin and core, and the checker is bound in.
`timescale 1ns/100ps
module mrs_reset_sequencer_tb
  import mrs_pkg::*;
;
  logic ref_clk, reset, psel, penable, pwrite, pready_ff, pslverr_ff, irq_ff, e;
  logic ext_reset_pin_n, halt_exec, clr_wdt_exec, wake_req, core_run_ff, pc_sp_clear_ff;
  logic unit_reset_ff, timeout_flag_ff, powerdown_flag_ff, pin_low, halt_cmd, wake_cmd, kick_en;
  logic [7:0] paddr, watchdog_scale_ff, port_a_data_ff, port_a_dir_ff, audio_pwm_ctrl_ff;
  logic [6:0] irq_control_ff;
  logic [3:0] port_b_data_ff, port_b_dir_ff;
  logic [31:0] pwdata, prdata_ff, rs, q, r, pw;
  logic [7:0] ra [7];
  logic [31:0] rv [7];
  int errors, n_checks, n;
  mrs_reset_sequencer #(.WDT_BASE(8)) dut (.*);
  mrs_core_model u_core (.*);
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd
  function automatic logic [31:0] exp_rd(input logic [7:0] a, input logic [31:0] d);
    case (a)
      OFS_IRQ_CTRL: return {25'h0, d[6:0]};
      OFS_PORT_B_DATA, OFS_PORT_B_DIR: return {28'h0, d[3:0]};
      OFS_PWM_CTRL: return {24'h0, d[7:0] & 8'h8d};
      default: return {24'h0, d[7:0]};
    endcase
  endfunction : exp_rd
  task automatic stop_test();
    if (errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic flags(input logic [1:0] ex);
    chk("flags", {30'h0, timeout_flag_ff, powerdown_flag_ff}, {30'h0, ex});
  endtask : flags
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready_ff !== 1'b1 && k < 64) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 64) errors++;
    q = prdata_ff;
    e = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    chk("read", q, ex);
  endtask : rd
  task automatic wait_run();
    n = 0;
    @(posedge ref_clk);
    while (core_run_ff !== 1'b1 && n < 4000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 4000) errors++;
    @(posedge ref_clk);
  endtask : wait_run
  task automatic wait_to();
    int k;
    k = 0;
    @(posedge ref_clk);
    while (timeout_flag_ff !== 1'b1 && k < 4000) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 4000) errors++;
    @(posedge ref_clk);
  endtask : wait_to
  task automatic pin_pulse();
    pin_low <= 1'b1;
    repeat (12) @(posedge ref_clk);
    pin_low <= 1'b0;
    wait_run();
  endtask : pin_pulse
  task automatic halt();
    halt_cmd <= 1'b1;
    @(posedge ref_clk);
    halt_cmd <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : halt
  // ---------------------------------------------------------------------------
  // Clock, watchdog and scenarios
  // ---------------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    stop_test();
  end
  initial begin
    errors = 0;
    n_checks = 0;
    rs = 32'h751e;
    ra = '{OFS_WDT_SCALE, OFS_IRQ_CTRL, OFS_PORT_A_DATA, OFS_PORT_A_DIR, OFS_PORT_B_DATA, OFS_PORT_B_DIR, OFS_PWM_CTRL};
    rv = '{32'h07, 32'h00, 32'hff, 32'hff, 32'h0f, 32'h0f, 32'h00};
    reset = 1'b1;
    {psel, penable, pwrite, pin_low, halt_cmd, wake_cmd, kick_en} = 7'h01;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    wait_run();
    chk("sst", n, SST_PULSES);
    flags(2'b00);
    for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
    for (int i = 1; i < 7; i++) begin
      r = rnd();
      apb(1'b1, ra[i], r);
      rd(ra[i], exp_rd(ra[i], r));
    end
    pw = exp_rd(OFS_PWM_CTRL, r);
    rd(8'h40, 32'h0);
    chk("slverr", {31'h0, e}, 32'h1);
    apb(1'b1, OFS_STATUS, 32'h3);
    flags(2'b00);
    apb(1'b1, OFS_EV_MASK, 32'h0);
    apb(1'b0, OFS_EV_STATUS, 32'h0);
    pin_pulse();
    chk("resume", {31'h0, n < 32}, 32'h1);
    flags(2'b00);
    for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
    rd(OFS_PWM_CTRL, pw);
    chk("irq", {31'h0, irq_ff}, 32'h0);
    apb(1'b1, OFS_EV_MASK, 32'h1);
    @(posedge ref_clk);
    chk("irq", {31'h0, irq_ff}, 32'h1);
    rd(OFS_EV_STATUS, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk("irq", {31'h0, irq_ff}, 32'h0);
    halt();
    flags(2'b01);
    rd(OFS_STATUS, 32'h6);
    wake_cmd <= 1'b1;
    @(posedge ref_clk);
    wake_cmd <= 1'b0;
    wait_run();
    chk("wake", {31'h0, n >= 1024}, 32'h1);
    flags(2'b01);
    repeat (100) @(posedge ref_clk);
    flags(2'b00);
    halt();
    pin_pulse();
    chk("pin_halt", {31'h0, n >= 1024}, 32'h1);
    flags(2'b01);
    repeat (100) @(posedge ref_clk);
    kick_en <= 1'b0;
    apb(1'b1, OFS_WDT_SCALE, 32'h0);
    wait_to();
    wait_run();
    flags(2'b10);
    rd(OFS_WDT_SCALE, 32'h07);
    kick_en <= 1'b1;
    r = rnd();
    apb(1'b1, OFS_PORT_A_DATA, r);
    halt();
    apb(1'b1, OFS_WDT_SCALE, 32'h0);
    wait_to();
    flags(2'b11);
    chk("port_a", {24'h0, port_a_data_ff}, {24'h0, r[7:0]});
    chk("scale", {24'h0, watchdog_scale_ff}, 32'h0);
    wait_run();
    chk("warm", {31'h0, n > 1000}, 32'h1);
    stop_test();
  end
endmodule : mrs_reset_sequencer_tb

// ### mrs_watchdog_timer.sv
// Watchdog timer: base period times a power-of-two scale, one-cycle overflow pulse.
// Assumes clear is a level from the sequencer and scale is the low three bits of the scale register.
`timescale 1ns/100ps
module mrs_watchdog_timer
  import mrs_pkg::*;
#(
  parameter int WDT_BASE = WDT_BASE_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic reset,
  mrs_wdt_if.wdt w
);

  logic [WDT_CW-1:0] cnt_ff;
  logic ovf_ff;
  logic [WDT_CW-1:0] limit;

  assign limit = (WDT_CW'(WDT_BASE) << w.scale) - WDT_CW'(1);
  assign w.overflow = ovf_ff;

  // ---------------------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_ff <= '0;
      ovf_ff <= 1'b0;
    end else if (w.clear || !w.enable) begin
      cnt_ff <= '0;
      ovf_ff <= 1'b0;
    end else if (cnt_ff >= limit) begin
      // Greater-or-equal also catches a count already past a newly lowered limit.
      cnt_ff <= '0;
      ovf_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + WDT_CW'(1);
      ovf_ff <= 1'b0;
    end
  end

endmodule : mrs_watchdog_timer

// ### mrs_wdt_if.sv
// Interface between the sequencer and its watchdog timer.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface mrs_wdt_if;
  logic clear;
  logic enable;
  logic [2:0] scale;
  logic overflow;
  modport ctrl (output clear, output enable, output scale, input overflow);
  modport wdt (input clear, input enable, input scale, output overflow);
endinterface : mrs_wdt_if
